// ===== design/pmsw_ctrl.sv
// Purpose: Power-mode sleep and wake controller with its register file
// Assumes: 32-bit peripheral accesses; wake pin is asynchronous; rtc count is on this clock
// Notes: Slow sleep clock is an enable pulse from a divider of the system clock
`timescale 1ns/10ps
`default_nettype none
`include "pmsw_params.svh"
module pmsw_ctrl
   import pmsw_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Peripheral register access
   input wire pmsw_req_t req,
   input wire logic [3:0] req_size,
   output logic [31:0] rdata,
   output logic ack,
   output logic err,
   // Wake sources
   input wire logic wake_pin,
   input wire logic [63:0] rtc_count,
   // Supply health
   input wire logic [6:0] supply_good,
   // Outputs to regulators and tile
   output var pmsw_supply_t supply,
   output logic use_por_levels,
   output logic usb_pwrup_sel,
   output logic usb_pwrdn_sel,
   output logic use_default_clk,
   output logic [2:0] seq_state
);
   pmsw_state_t state_ff, nxt_state;
   logic [31:0] gen_ff, wtl_ff, wth_ff;
   logic [31:0] st_ff [0:5];
   logic [31:0] swc_ff, hlth_ff, core_ff, pll_ff;
   logic [31:0] dwell_ff, nxt_dwell;
   logic [8:0] div_ff;
   logic pin_s1_ff, pin_s2_ff;
   pmsw_supply_t supply_ff;
   logic [31:0] rdata_ff;
   logic ack_ff, err_ff;

   // Register index of each state in the ring order of the enum
   function automatic logic [2:0] st_idx(input pmsw_state_t s);
      unique case (s)
         ST_FULL_RUN: st_idx = 3'h3;
         ST_DESCENT_ONE: st_idx = 3'h4;
         ST_DESCENT_TWO: st_idx = 3'h5;
         ST_DEEP_IDLE: st_idx = 3'h0;
         ST_RISE_ONE: st_idx = 3'h1;
         ST_RISE_TWO: st_idx = 3'h2;
      endcase
   endfunction

   // Access decode; only full-word accesses are honoured
   // word access only
   wire word_ok = (req_size == 4'hf);
   wire acc = (req.wr | req.rd);
   wire [7:0] a = req.addr;
   wire hit_st = (a >= `PMSW_OFF_IDLE) && (a <= `PMSW_OFF_D2) && (a[1:0] == 2'h0);
   wire [2:0] st_wi = 3'((a - `PMSW_OFF_IDLE) >> 2);
   wire mapped = hit_st || (a == `PMSW_OFF_GEN) || (a == `PMSW_OFF_WTL) || (a == `PMSW_OFF_WTH)
      || (a == `PMSW_OFF_SEQ) || (a == `PMSW_OFF_SWC) || (a == `PMSW_OFF_HLTH)
      || (a == `PMSW_OFF_CORE) || (a == `PMSW_OFF_PLL);
   wire good_acc = acc && word_ok && mapped;
   wire wr_ok = req.wr && good_acc;
   wire sleep_req = wr_ok && (a == `PMSW_OFF_GEN) && req.wdata[`PMSW_GEN_SLEEP];
   wire reapply_req = wr_ok && (a == `PMSW_OFF_GEN) && req.wdata[`PMSW_GEN_REAPPLY];

   // Slow-clock enable from a divider of the system clock
   wire slow_tick = (div_ff == 9'(`PMSW_SLOW_DIV - 1));
   wire asleep = (state_ff == ST_DEEP_IDLE);
   wire clk_default = gen_ff[`PMSW_GEN_CLK_SEL] || !asleep;
   wire cnt_en = clk_default || slow_tick;

   // Wake conditions
   // compare width
   wire [31:0] hi_cmp = gen_ff[`PMSW_GEN_CMP64] ? wth_ff : 32'h0;
   wire [31:0] hi_cnt = gen_ff[`PMSW_GEN_CMP64] ? rtc_count[63:32] : 32'h0;
   wire time_hit = asleep && gen_ff[`PMSW_GEN_TMR_WAKE] && ({hi_cnt, rtc_count[31:0]} >= {hi_cmp, wtl_ff});
   wire pin_hit = asleep && gen_ff[`PMSW_GEN_PIN_WAKE] && (pin_s2_ff == gen_ff[`PMSW_GEN_PIN_POL]);
   wire wake_evt = time_hit || pin_hit;

   // Wake source and slow idle clock checks
   chk_low_word_wake: assert property (@(posedge clock) disable iff (!resetn)
      (asleep && gen_ff[`PMSW_GEN_TMR_WAKE] && !gen_ff[`PMSW_GEN_CMP64] && rtc_count[31:0] >= wtl_ff) |-> time_hit)
      else $error("low word match did not wake");
   chk_upper_word_hold: assert property (@(posedge clock) disable iff (!resetn)
      (asleep && gen_ff[`PMSW_GEN_CMP64] && rtc_count[63:32] < wth_ff) |-> !time_hit)
      else $error("upper word ignored in wide compare");
   chk_full_run_state_no_wake: assert property (@(posedge clock) disable iff (!resetn)
      !asleep |-> !wake_evt)
      else $error("wake condition seen while not asleep");
   chk_pin_polarity: assert property (@(posedge clock) disable iff (!resetn)
      (gen_ff[`PMSW_GEN_PIN_POL] != pin_s2_ff) |-> !pin_hit)
      else $error("pin woke at wrong level");
   chk_slow_clock: assert property (@(posedge clock) disable iff (!resetn)
      (asleep && !gen_ff[`PMSW_GEN_CLK_SEL]) |-> !use_default_clk)
      else $error("default clock kept in idle");
   chk_slow_dwell: assert property (@(posedge clock) disable iff (!resetn)
      (asleep && !gen_ff[`PMSW_GEN_CLK_SEL] && !slow_tick) |=> $stable(dwell_ff))
      else $error("idle dwell counted without slow tick");

   // Dwell target and supply health of the current state
   wire [31:0] cur_st = st_ff[st_idx(state_ff)];
   wire [4:0] dwell_log = cur_st[`PMSW_ST_DWELL_HI:`PMSW_ST_DWELL_LO];
   wire [31:0] dwell_need = 32'h1 << dwell_log;
   wire dwell_done = (dwell_ff >= dwell_need - 32'h1) && cnt_en;
   wire [6:0] en_vec = {4'h0, cur_st[`PMSW_ST_IO_EN], cur_st[`PMSW_ST_PLL_EN], cur_st[`PMSW_ST_CSW_EN]};
   wire pgood = ((en_vec & ~supply_good) == 7'h0);

   // Next state of the ring
   // ring order
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_FULL_RUN: if (sleep_req) nxt_state = ST_DESCENT_ONE;
         ST_DESCENT_ONE: if (dwell_done) nxt_state = ST_DESCENT_TWO;
         ST_DESCENT_TWO: if (dwell_done) nxt_state = ST_DEEP_IDLE;
         ST_DEEP_IDLE: if (dwell_done && wake_evt) nxt_state = ST_RISE_ONE;
         ST_RISE_ONE: if (dwell_done && pgood) nxt_state = ST_RISE_TWO;
         ST_RISE_TWO: if (dwell_done && pgood) nxt_state = ST_FULL_RUN;
      endcase
   end

   // Ring order checks
   chk_run_holds: assert property (@(posedge clock) disable iff (!resetn)
      (state_ff == ST_FULL_RUN && !sleep_req) |=> state_ff == ST_FULL_RUN)
      else $error("left full run without request");
   chk_descent_order: assert property (@(posedge clock) disable iff (!resetn)
      (state_ff == ST_DESCENT_TWO) |=> (state_ff == ST_DESCENT_TWO || state_ff == ST_DEEP_IDLE))
      else $error("descent left the ring");
   chk_rise_two_pgood: assert property (@(posedge clock) disable iff (!resetn)
      (state_ff == ST_RISE_TWO && !pgood) |=> state_ff == ST_RISE_TWO)
      else $error("second rise advanced without power good");

   // Dwell counter restarts on each state change and saturates
   always_comb begin
      nxt_dwell = dwell_ff;
      if (nxt_state != state_ff)
         nxt_dwell = 32'h0;
      else if (cnt_en && dwell_ff != 32'hffff_ffff)
         nxt_dwell = dwell_ff + 32'h1;
   end

   // Settings applied for the state being entered, or re-applied on request
   // re-apply full run
   wire [31:0] nxt_st = st_ff[st_idx(nxt_state)];
   wire apply = (nxt_state != state_ff) || (reapply_req && state_ff == ST_FULL_RUN);
   // A state change wins over a re-apply written in the same cycle
   wire [31:0] ap = (nxt_state != state_ff) ? nxt_st : st_ff[3];

   // Sequencer, divider and pin synchroniser
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_ff <= ST_FULL_RUN;
         dwell_ff <= 32'h0;
         div_ff <= 9'h0;
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         dwell_ff <= nxt_dwell;
         div_ff <= slow_tick ? 9'h0 : div_ff + 9'h1;
         pin_s1_ff <= wake_pin;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // Applied supply and clock settings
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         supply_ff <= '{tile_clk_off: 1'b0, analogue_pfm: 1'b0, core_pfm: 1'b0, io_supply_en: 1'b1,
                        pll_reg_en: 1'b1, analogue_sw_en: 1'b1, core_sw_en: 1'b1};
      end else if (apply) begin
         supply_ff.tile_clk_off <= ap[`PMSW_ST_CLK_OFF];
         supply_ff.analogue_pfm <= ap[`PMSW_ST_ASW_PFM];
         supply_ff.core_pfm <= ap[`PMSW_ST_CSW_PFM];
         supply_ff.io_supply_en <= ap[`PMSW_ST_IO_EN];
         supply_ff.pll_reg_en <= ap[`PMSW_ST_PLL_EN];
         supply_ff.analogue_sw_en <= ap[`PMSW_ST_ASW_EN];
         supply_ff.core_sw_en <= ap[`PMSW_ST_CSW_EN];
      end
   end

   // Settings of the entered state reach the outputs with the state
   chk_tile_gate: assert property (@(posedge clock) disable iff (!resetn)
      $changed(state_ff) |-> supply.tile_clk_off == $past(nxt_st[`PMSW_ST_CLK_OFF]))
      else $error("tile clock gate not applied");
   chk_mod_select: assert property (@(posedge clock) disable iff (!resetn)
      $changed(state_ff) |-> {supply.analogue_pfm, supply.core_pfm} ==
         $past({nxt_st[`PMSW_ST_ASW_PFM], nxt_st[`PMSW_ST_CSW_PFM]}))
      else $error("modulation not applied");
   chk_io_enable: assert property (@(posedge clock) disable iff (!resetn)
      $changed(state_ff) |-> supply.io_supply_en == $past(nxt_st[`PMSW_ST_IO_EN]))
      else $error("io supply enable not applied");
   chk_pll_enable: assert property (@(posedge clock) disable iff (!resetn)
      $changed(state_ff) |-> supply.pll_reg_en == $past(nxt_st[`PMSW_ST_PLL_EN]))
      else $error("pll regulator enable not applied");
   chk_core_enable: assert property (@(posedge clock) disable iff (!resetn)
      $changed(state_ff) |-> supply.core_sw_en == $past(nxt_st[`PMSW_ST_CSW_EN]))
      else $error("core switcher enable not applied");
   chk_reapply_run: assert property (@(posedge clock) disable iff (!resetn)
      (reapply_req && state_ff == ST_FULL_RUN && nxt_state == ST_FULL_RUN) |=>
         {supply.io_supply_en, supply.pll_reg_en, supply.core_sw_en} ==
         $past({st_ff[3][`PMSW_ST_IO_EN], st_ff[3][`PMSW_ST_PLL_EN], st_ff[3][`PMSW_ST_CSW_EN]}))
      else $error("full run settings not re-applied");

   // General control, wake time and level registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         gen_ff <= `PMSW_GEN_RESET;
         wtl_ff <= 32'h0;
         wth_ff <= 32'h0;
         swc_ff <= 32'h0;
         hlth_ff <= 32'h0;
         core_ff <= 32'h0;
         pll_ff <= 32'h0;
      end else if (wr_ok) begin
         if (a == `PMSW_OFF_GEN) gen_ff <= req.wdata & `PMSW_GEN_MASK;
         if (a == `PMSW_OFF_WTL) wtl_ff <= req.wdata;
         if (a == `PMSW_OFF_WTH) wth_ff <= req.wdata;
         if (a == `PMSW_OFF_SWC) swc_ff <= req.wdata;
         if (a == `PMSW_OFF_HLTH) hlth_ff <= req.wdata;
         if (a == `PMSW_OFF_CORE) core_ff <= req.wdata;
         if (a == `PMSW_OFF_PLL) pll_ff <= req.wdata;
      end
   end

   // General control bits drive their selects from the next cycle
   chk_usb_up_sel: assert property (@(posedge clock) disable iff (!resetn)
      (wr_ok && a == `PMSW_OFF_GEN) |=> usb_pwrup_sel == $past(req.wdata[`PMSW_GEN_USB_UP]))
      else $error("usb power-up select not taken");
   chk_usb_down_sel: assert property (@(posedge clock) disable iff (!resetn)
      (wr_ok && a == `PMSW_OFF_GEN) |=> usb_pwrdn_sel == $past(req.wdata[`PMSW_GEN_USB_DN]))
      else $error("usb power-down select not taken");
   chk_por_select: assert property (@(posedge clock) disable iff (!resetn)
      (wr_ok && a == `PMSW_OFF_GEN) |=> use_por_levels == $past(req.wdata[`PMSW_GEN_POR_LVL]))
      else $error("level source select not taken");

   // Per-state settings registers, one per state
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_st
         localparam logic [31:0] RV = (gi == 0) ? `PMSW_RST_IDLE : (gi == 1) ? `PMSW_RST_R1 :
            (gi == 2) ? `PMSW_RST_R2 : (gi == 3) ? `PMSW_RST_RUN : (gi == 4) ? `PMSW_RST_D1 : `PMSW_RST_D2;
         localparam logic [31:0] WM = (gi == 3) ? (`PMSW_ST_RUN_MASK & ~32'h2) : (`PMSW_ST_MASK & ~32'h2);
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               st_ff[gi] <= RV;
            end else if (wr_ok && hit_st && st_wi == 3'(gi)) begin
               st_ff[gi] <= (req.wdata & WM) | (RV & 32'h2);
            end
         end
      end
   endgenerate

   // Read mux
   wire [31:0] rd_mux = hit_st ? st_ff[st_wi] :
      (a == `PMSW_OFF_GEN) ? (gen_ff & ~32'h42) :
      (a == `PMSW_OFF_WTL) ? wtl_ff :
      (a == `PMSW_OFF_WTH) ? wth_ff :
      (a == `PMSW_OFF_SEQ) ? {29'h0, state_ff} :
      (a == `PMSW_OFF_SWC) ? swc_ff :
      (a == `PMSW_OFF_HLTH) ? {25'h0, supply_good} :
      (a == `PMSW_OFF_CORE) ? core_ff : pll_ff;

   // Answer one cycle after each access
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= 32'h0;
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         ack_ff <= acc;
         err_ff <= acc && !good_acc;
         rdata_ff <= (req.rd && good_acc) ? rd_mux : 32'h0;
      end
   end

   // Refused reads answer with an error and no data
   chk_bad_read: assert property (@(posedge clock) disable iff (!resetn)
      (req.rd && !word_ok) |=> ack && err && rdata == 32'h0)
      else $error("narrow read answered with data");

   // Outputs
   assign rdata = rdata_ff;
   assign ack = ack_ff;
   assign err = err_ff;
   assign supply = supply_ff;
   assign use_por_levels = gen_ff[`PMSW_GEN_POR_LVL];
   assign usb_pwrup_sel = gen_ff[`PMSW_GEN_USB_UP];
   assign usb_pwrdn_sel = gen_ff[`PMSW_GEN_USB_DN];
   assign use_default_clk = clk_default;
   assign seq_state = state_ff;

   // Checks
   chk_sleep_start: assert property (@(posedge clock) disable iff (!resetn)
      (state_ff == ST_FULL_RUN && sleep_req) |=> state_ff == ST_DESCENT_ONE)
      else $error("sleep request did not start descent");
   chk_idle_stays: assert property (@(posedge clock) disable iff (!resetn)
      (asleep && !wake_evt) |=> asleep)
      else $error("left idle without wake");
   chk_wake_exit: assert property (@(posedge clock) disable iff (!resetn)
      (asleep && wake_evt && dwell_done) |=> state_ff == ST_RISE_ONE)
      else $error("wake did not leave idle");
   chk_dwell_min: assert property (@(posedge clock) disable iff (!resetn)
      ($changed(state_ff) && $past(state_ff) != ST_FULL_RUN) |-> $past(dwell_done))
      else $error("state left before dwell");
   chk_rise_pgood: assert property (@(posedge clock) disable iff (!resetn)
      (state_ff == ST_RISE_ONE && !pgood) |=> state_ff == ST_RISE_ONE)
      else $error("advanced without power good");
   chk_sel_clear: assert property (@(posedge clock) disable iff (!resetn)
      ##1 gen_ff[`PMSW_GEN_SLEEP] == 1'b0)
      else $error("sleep bit held");
   chk_bad_size: assert property (@(posedge clock) disable iff (!resetn)
      (req.wr && !word_ok) |=> err && $stable(gen_ff))
      else $error("narrow write accepted");
   chk_pin_wake: assert property (@(posedge clock) disable iff (!resetn)
      (asleep && !gen_ff[`PMSW_GEN_PIN_WAKE] && !gen_ff[`PMSW_GEN_TMR_WAKE]) |=> asleep)
      else $error("woke with sources off");
   chk_ana_ro: assert property (@(posedge clock) disable iff (!resetn)
      st_ff[0][`PMSW_ST_ASW_EN] == 1'b0)
      else $error("idle analogue bit set");
   cov_full_ring: cover property (@(posedge clock) disable iff (!resetn)
      state_ff == ST_RISE_TWO ##1 state_ff == ST_FULL_RUN);
   cov_time_wake: cover property (@(posedge clock) disable iff (!resetn) time_hit && dwell_done);
   cov_pin_wake: cover property (@(posedge clock) disable iff (!resetn) pin_hit && dwell_done);
   cov_slow_idle: cover property (@(posedge clock) disable iff (!resetn) asleep && !use_default_clk && slow_tick);
   cov_reapply: cover property (@(posedge clock) disable iff (!resetn) reapply_req && state_ff == ST_FULL_RUN);
endmodule
`default_nettype wire

// ===== design/pmsw_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the power-mode controller
// Assumes: Included by the package and the design module
// Notes: Definitions only
`ifndef PMSW_PARAMS_SVH
`define PMSW_PARAMS_SVH
`define PMSW_OFF_GEN 8'h00
`define PMSW_OFF_WTL 8'h04
`define PMSW_OFF_WTH 8'h08
`define PMSW_OFF_IDLE 8'h0c
`define PMSW_OFF_R1 8'h10
`define PMSW_OFF_R2 8'h14
`define PMSW_OFF_RUN 8'h18
`define PMSW_OFF_D1 8'h1c
`define PMSW_OFF_D2 8'h20
`define PMSW_OFF_SEQ 8'h24
`define PMSW_OFF_SWC 8'h2c
`define PMSW_OFF_HLTH 8'h30
`define PMSW_OFF_CORE 8'h34
`define PMSW_OFF_PLL 8'h40
// General control fields
`define PMSW_GEN_USB_UP 9
`define PMSW_GEN_USB_DN 8
`define PMSW_GEN_POR_LVL 7
`define PMSW_GEN_REAPPLY 6
`define PMSW_GEN_CMP64 5
`define PMSW_GEN_TMR_WAKE 4
`define PMSW_GEN_PIN_POL 3
`define PMSW_GEN_PIN_WAKE 2
`define PMSW_GEN_SLEEP 1
`define PMSW_GEN_CLK_SEL 0
`define PMSW_GEN_RESET 32'h0000_0008
`define PMSW_GEN_MASK 32'h0000_03bd
// Per-state fields
`define PMSW_ST_DWELL_HI 20
`define PMSW_ST_DWELL_LO 16
`define PMSW_ST_CLK_OFF 14
`define PMSW_ST_ASW_PFM 9
`define PMSW_ST_CSW_PFM 8
`define PMSW_ST_IO_EN 5
`define PMSW_ST_PLL_EN 4
`define PMSW_ST_ASW_EN 1
`define PMSW_ST_CSW_EN 0
`define PMSW_ST_MASK 32'h001f_4333
`define PMSW_ST_RUN_MASK 32'h0000_4333
// Reset values of the six state registers
`define PMSW_RST_IDLE 32'h0010_0000
`define PMSW_RST_R1 32'h0010_0020
`define PMSW_RST_R2 32'h0010_0033
`define PMSW_RST_RUN 32'h0000_0033
`define PMSW_RST_D1 32'h0010_0033
`define PMSW_RST_D2 32'h0010_0033
// Slow sleep oscillator and rate of the system clock
`define PMSW_SLOW_HZ 31250
`define PMSW_CLK_HZ 10000000
`define PMSW_SLOW_DIV (`PMSW_CLK_HZ / `PMSW_SLOW_HZ)
`endif

// ===== design/pmsw_pkg.sv
// Purpose: Types of the power-mode controller
// Assumes: pmsw_params.svh holds the numbers
// Notes: States form a ring
`include "pmsw_params.svh"
package pmsw_pkg;
   typedef enum logic [2:0] {
      ST_FULL_RUN,
      ST_DESCENT_ONE,
      ST_DESCENT_TWO,
      ST_DEEP_IDLE,
      ST_RISE_ONE,
      ST_RISE_TWO
   } pmsw_state_t;
   // Outputs applied to the regulators and the tile
   typedef struct packed {
      logic tile_clk_off;
      logic analogue_pfm;
      logic core_pfm;
      logic io_supply_en;
      logic pll_reg_en;
      logic analogue_sw_en;
      logic core_sw_en;
   } pmsw_supply_t;
   // Peripheral register access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } pmsw_req_t;
endpackage

// ===== dv/pmsw_partner.sv
// Purpose: Model of the regulators, wake pin and real-time counter
// Assumes: Each regulator reports good a set number of cycles after its enable
// Notes: A disabled regulator reports not good at once
`timescale 1ns/10ps
`default_nettype none
module pmsw_partner
   import pmsw_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Enables from the controller
   input wire pmsw_supply_t supply,
   // Bench controls
   input wire logic pin_level,
   input wire logic [3:0] ramp,
   // Answers to the controller
   output logic [6:0] supply_good,
   output logic wake_pin,
   output logic [63:0] rtc_count
);
   logic [2:0][3:0] cnt_ff;
   wire logic [2:0] en = {supply.io_supply_en, supply.pll_reg_en, supply.core_sw_en};
   // Ramp counters and free-running time count
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= '0;
         rtc_count <= 64'h0;
      end else begin
         rtc_count <= rtc_count + 64'h1;
         for (int i = 0; i < 3; i++) begin
            cnt_ff[i] <= !en[i] ? 4'h0 : (cnt_ff[i] == 4'hf ? 4'hf : cnt_ff[i] + 4'h1);
         end
      end
   end
   // Good once the ramp has elapsed; unused bits stay low
   always_comb begin
      supply_good = 7'h0;
      for (int i = 0; i < 3; i++) begin
         supply_good[i] = en[i] && (cnt_ff[i] >= ramp);
      end
   end
   assign wake_pin = pin_level;
endmodule
`default_nettype wire

// ===== dv/pmsw_ctrl_tb_top.sv
// Purpose: Self-checking bench of the power-mode controller
// Assumes: Dwell fields are shortened by register writes
// Notes: Bus answers are matched through a queue of expected responses
`timescale 1ns/10ps
`default_nettype none
`include "pmsw_params.svh"
module pmsw_ctrl_tb_top
   import pmsw_pkg::*;
;
   logic clock, resetn, pin_level, ack, err, por, usb_up, usb_dn, dflt_clk, wake_pin;
   logic [3:0] req_size, ramp;
   logic [31:0] rdata;
   logic [63:0] rtc_count;
   logic [6:0] supply_good;
   logic [2:0] seq_state;
   pmsw_req_t req;
   pmsw_supply_t supply;
   logic [32:0] exp_q [$];
   int bad_count, checked;
   localparam logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
   localparam logic [31:0] rstv [9] = '{`PMSW_GEN_RESET, 32'h0, 32'h0, `PMSW_RST_IDLE, `PMSW_RST_R1,
      `PMSW_RST_R2, `PMSW_RST_RUN, `PMSW_RST_D1, `PMSW_RST_D2};

   pmsw_ctrl dut (.clock(clock), .resetn(resetn), .req(req), .req_size(req_size), .rdata(rdata),
      .ack(ack), .err(err), .wake_pin(wake_pin), .rtc_count(rtc_count), .supply_good(supply_good),
      .supply(supply), .use_por_levels(por), .usb_pwrup_sel(usb_up), .usb_pwrdn_sel(usb_dn),
      .use_default_clk(dflt_clk), .seq_state(seq_state));
   pmsw_partner far_side (.clock(clock), .resetn(resetn), .supply(supply), .pin_level(pin_level),
      .ramp(ramp), .supply_good(supply_good), .wake_pin(wake_pin), .rtc_count(rtc_count));

   // Verdict and end of run
   task automatic print_verdict();
      if (exp_q.size() != 0) bad_count++;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Comparison of one value
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Cycle steps, bus cycles and state waits
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clock);
         #10;
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] sz,
      input logic [32:0] e);
      tick(1);
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      req_size = sz;
      exp_q.push_back(e);
      tick(1);
      req = '0;
      req_size = 4'hf;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf, 33'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf, {1'b0, e});
   endtask
   task automatic wait_state(input logic [2:0] s, input int n);
      int i;
      i = 0;
      while (seq_state !== s && i < n) begin
         tick(1);
         i++;
      end
      chk("seq_state", seq_state, s);
   endtask
   task automatic nap(input logic [31:0] g);
      wr(8'h00, g | 32'h2);
      wait_state(3'h3, 20);
   endtask
   function automatic pmsw_supply_t smap(input logic [31:0] r);
      return {r[14], r[9], r[8], r[5], r[4], r[1], r[0]};
   endfunction

   // Response watcher takes the oldest note at each acknowledge
   always @(negedge clock) begin
      if (ack === 1'b1) begin
         if (exp_q.size() == 0) chk("ack", 1, 0);
         else chk("response", {err, rdata}, exp_q.pop_front());
      end
   end
   // Clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      print_verdict();
   end
   // Main sequence
   initial begin
      logic [31:0] v;
      logic [63:0] t;
      int n;
      resetn = 1'b0;
      req = '0;
      req_size = 4'hf;
      pin_level = 1'b0;
      ramp = 4'h0;
      v = $urandom(32'h832512c2);
      repeat (12) @(posedge clock);
      #10;
      resetn = 1'b1;
      chk("supply", supply, 7'h0f);
      foreach (offs[i]) rd(offs[i], rstv[i]);
      bus(1'b0, 8'h28, 32'h0, 4'hf, {1'b1, 32'h0});
      bus(1'b1, 8'h04, 32'h1234, 4'h3, {1'b1, 32'h0});
      rd(8'h04, 32'h0);
      $display("test reset done");
      for (int i = 3; i < 9; i++) begin
         v = $urandom();
         wr(offs[i], v);
         rd(offs[i], (v & (i == 6 ? `PMSW_ST_RUN_MASK : `PMSW_ST_MASK) & ~32'h2) | (rstv[i] & 32'h2));
      end
      v = $urandom() & `PMSW_GEN_MASK;
      wr(8'h00, v);
      rd(8'h00, v);
      chk("usb_up", usb_up, v[9]);
      chk("usb_dn", usb_dn, v[8]);
      chk("por", por, v[7]);
      chk("dflt_clk", dflt_clk, 1);
      wr(8'h18, 32'h130);
      chk("supply", supply, 7'h0f);
      wr(8'h00, 32'h48);
      tick(2);
      chk("supply", supply, smap(32'h132));
      rd(8'h00, 32'h8);
      $display("test registers done");
      wr(8'h1c, 32'h100);
      wr(8'h20, 32'h200);
      wr(8'h0c, 32'h4000);
      wr(8'h10, 32'h31);
      wr(8'h14, 32'h33);
      wr(8'h18, 32'h33);
      ramp = 4'hf;
      wr(8'h00, 32'h0f);
      chk("seq_state", seq_state, 3'h1);
      chk("supply", supply, smap(32'h102));
      wait_state(3'h2, 4);
      chk("supply", supply, smap(32'h202));
      wait_state(3'h3, 8);
      chk("supply", supply, smap(32'h4000));
      chk("dflt_clk", dflt_clk, 1);
      tick(30);
      chk("seq_state", seq_state, 3'h3);
      pin_level = 1'b1;
      wait_state(3'h4, 20);
      chk("supply", supply, smap(32'h31));
      tick(8);
      chk("seq_state", seq_state, 3'h4);
      wait_state(3'h5, 30);
      wait_state(3'h0, 40);
      ramp = 4'h0;
      rd(8'h00, 32'h0d);
      nap(32'h05);
      tick(30);
      chk("seq_state", seq_state, 3'h3);
      pin_level = 1'b0;
      wait_state(3'h0, 60);
      $display("test pin wake done");
      t = rtc_count + 64'h12c;
      wr(8'h04, t[31:0]);
      wr(8'h08, 32'hffffffff);
      nap(32'h11);
      while (rtc_count < t - 64'h5) tick(1);
      chk("seq_state", seq_state, 3'h3);
      wait_state(3'h4, 20);
      wait_state(3'h0, 60);
      nap(32'h31);
      tick(40);
      chk("seq_state", seq_state, 3'h3);
      wr(8'h08, 32'h0);
      wait_state(3'h4, 20);
      wait_state(3'h0, 60);
      $display("test timer wake done");
      wr(8'h0c, 32'h0001_0000);
      pin_level = 1'b1;
      nap(32'h0c);
      chk("dflt_clk", dflt_clk, 0);
      tick(300);
      chk("seq_state", seq_state, 3'h3);
      wait_state(3'h4, 1000);
      wait_state(3'h0, 60);
      wr(8'h0c, 32'h0003_0000);
      nap(32'h0d);
      n = 1;
      while (seq_state === 3'h3 && n < 40) begin
         tick(1);
         n++;
      end
      chk("dwell", n, (1 << 3) + 1);
      wait_state(3'h0, 60);
      $display("test dwell done");
      tick(4);
      print_verdict();
   end
endmodule
`default_nettype wire
